// *** flash_read_core.sv ***
// read modes, burst sequencing, wait signalling and bank command checks
//
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "flash_read_regs.svh"

// Functional notes
// - async reads only while read select is one
// - four-word page, low address bits ungated
// - first page access slow, same page fast
// - idle 150ns in async enters standby
// - async mode keeps wait asserted
// - burst starts edge after later enable fall
// - latency one to seven, one word per clock
// - length four, eight or continuous
// - data hold one or two clocks
// - sequential or interleaved, wrap or not
// - aligned start gives same sequence either way
// - wait asserted except while data valid
// - continuous crossing 64 inserts start-offset waits
// - wait polarity selectable, high default
// - non-burst modes hold wait asserted
// - single read: only first word valid
// - status, query, signature modes hold wait
// - one bank programs or erases at once
// - other-bank commands per bank state
// - same-bank commands per bank state
// - read select defaults to asynchronous
// - length codes 001, 010, 111 default
module flash_read_core
  import flash_read_pkg::*;
#(
  parameter int ADDR_W = 21,
  parameter int DATA_W = 16,
  parameter int RAND_ACC_NS = 64,
  parameter int PAGE_ACC_NS = 20
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic [31:0] o_prdata,
  // flash pins from host
  input wire ctl_pins_type i_pins,
  input wire logic [ADDR_W-1:0] i_addr,
  output logic o_wait,
  output logic [DATA_W-1:0] o_data,
  output logic o_data_valid,
  output logic o_standby,
  // array core
  output logic [ADDR_W-1:0] o_array_addr,
  input wire logic [DATA_W-1:0] i_array_data
);
  localparam logic [7:0] RAND_CYC = 8'((RAND_ACC_NS + `CLK_NS - 1) / `CLK_NS);
  localparam logic [7:0] PAGE_CYC = 8'((PAGE_ACC_NS + `CLK_NS - 1) / `CLK_NS);
  localparam logic [7:0] STBY_CYC = 8'(`STANDBY_CYC);

  // word address of burst word n
  function automatic logic [ADDR_W-1:0] word_addr(input logic [ADDR_W-1:0] st,
      input logic [ADDR_W-1:0] n, input cfg_type c);
    logic [ADDR_W-1:0] m;
    m = (c.burst_length_field == `LEN_8) ? ADDR_W'(`WORDS_8) : ADDR_W'(`WORDS_4);
    if (c.burst_length_field == `LEN_CONT || c.wrap_select_bit) begin
      word_addr = st + n;
    end else if (c.burst_order_bit) begin
      word_addr = (st & ~m) | ((st + n) & m);
    end else begin
      word_addr = (st & ~m) | ((st ^ n) & m);
    end
  endfunction : word_addr

  // acceptance of a command given the target bank state
  function automatic cmd_result_type check_cmd(input bank_state_type st, input logic same,
      input logic blk, input cmd_type c);
    cmd_result_type r;
    logic rd;
    rd = (c == CMD_RD_ARRAY) || (c == CMD_RD_STATUS) || (c == CMD_RD_CFI) || (c == CMD_RD_SIG);
    r.accepted = 1'b0;
    r.undefined_data = 1'b0;
    case (st)
      BK_IDLE: r.accepted = 1'b1;
      BK_PROG, BK_ERASE: begin
        r.accepted = rd || (c == CMD_SUSPEND);
        r.undefined_data = same && (c == CMD_RD_ARRAY);
      end
      BK_PSUSP: r.accepted = rd || (c == CMD_RESUME);
      BK_ESUSP: r.accepted = rd || (c == CMD_RESUME) || (c == CMD_PROGRAM);
      default: r.accepted = 1'b0;
    endcase
    if (same && blk && (st == BK_PSUSP || st == BK_ESUSP)
        && (c == CMD_RD_ARRAY || c == CMD_PROGRAM)) begin
      r.accepted = 1'b0;
    end
    check_cmd = r;
  endfunction : check_cmd

  // pin synchronisers
  ctl_pins_type pins1_ff, pins2_ff, prev_ff;
  logic [ADDR_W-1:0] addr1_ff, addr2_ff, prev_addr_ff;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pins1_ff <= '{link_clk: 1'b0, chip_en_n: 1'b1, latch_en_n: 1'b1};
      pins2_ff <= '{link_clk: 1'b0, chip_en_n: 1'b1, latch_en_n: 1'b1};
      prev_ff <= '{link_clk: 1'b0, chip_en_n: 1'b1, latch_en_n: 1'b1};
      addr1_ff <= '0;
      addr2_ff <= '0;
      prev_addr_ff <= '0;
    end else begin
      pins1_ff <= i_pins;
      pins2_ff <= pins1_ff;
      prev_ff <= pins2_ff;
      addr1_ff <= i_addr;
      addr2_ff <= addr1_ff;
      prev_addr_ff <= addr2_ff;
    end
  end

  // register state
  cfg_type cfg_ff, nxt_cfg;
  logic [3:0] busy_bank_ff, nxt_busy_bank;
  bank_state_type bank_st_ff, nxt_bank_st;
  rmode_type rmode_ff, nxt_rmode;
  cmd_result_type result_ff, nxt_result;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pslverr_ff, nxt_pslverr;
  logic hit;

  // link state
  burst_state_type bst_ff, nxt_bst;
  logic [2:0] lat_cnt_ff, nxt_lat_cnt;
  logic hold_ff, nxt_hold;
  logic [ADDR_W-1:0] word_n_ff, nxt_word_n, start_ff, nxt_start, arr_addr_ff, nxt_arr_addr;
  logic [1:0] gap_cnt_ff, nxt_gap_cnt;
  logic crossed_ff, nxt_crossed, single_ff, nxt_single, armed_ff, nxt_armed;
  logic valid_ff, nxt_valid, wait_asrt_ff, nxt_wait_asrt, standby_ff, nxt_standby;
  logic [ADDR_W-3:0] page_ff, nxt_page;
  logic [7:0] acc_cnt_ff, nxt_acc_cnt, idle_cnt_ff, nxt_idle_cnt;
  logic [DATA_W-1:0] data_ff;
  logic edge_hit, le_fall, ce_fall, activity, async_mode;
  logic [ADDR_W-1:0] next_word;

  assign o_pready = 1'b1;
  assign o_pslverr = pslverr_ff;
  assign o_prdata = prdata_ff;
  assign o_wait = cfg_ff.wait_polarity_bit ? wait_asrt_ff : ~wait_asrt_ff;
  assign o_data = data_ff;
  assign o_data_valid = valid_ff;
  assign o_standby = standby_ff;
  assign o_array_addr = arr_addr_ff;

  assign hit = (i_paddr == `CFG_OFS) || (i_paddr == `BANK_OFS) || (i_paddr == `CMD_OFS)
      || (i_paddr == `STAT_OFS);

  always_comb begin
    nxt_cfg = cfg_ff;
    nxt_busy_bank = busy_bank_ff;
    nxt_bank_st = bank_st_ff;
    nxt_rmode = rmode_ff;
    nxt_result = result_ff;
    nxt_prdata = prdata_ff;
    nxt_pslverr = 1'b0;
    if (i_psel && !i_penable) begin
      nxt_pslverr = !hit;
      if (i_paddr == `CFG_OFS) begin
        nxt_prdata = {16'h0000, cfg_ff};
      end else if (i_paddr == `BANK_OFS) begin
        nxt_prdata = {22'h000000, rmode_ff, 1'b0, bank_st_ff, busy_bank_ff};
      end else if (i_paddr == `STAT_OFS) begin
        nxt_prdata = {25'h0000000, bst_ff, valid_ff, standby_ff, result_ff};
      end else begin
        nxt_prdata = 32'h00000000;
      end
    end
    if (i_psel && i_penable && i_pwrite) begin
      if (i_paddr == `CFG_OFS) begin
        nxt_cfg = cfg_type'(i_pwdata[15:0]);
        nxt_cfg.rsv14 = 1'b0;
        nxt_cfg.rsv5_4 = 2'h0;
      end else if (i_paddr == `BANK_OFS) begin
        nxt_busy_bank = i_pwdata[`BANK_ID_LSB +: 4];
        nxt_bank_st = bank_state_type'(i_pwdata[`BANK_ST_LSB +: 3]);
        nxt_rmode = rmode_type'(i_pwdata[`BANK_RM_LSB +: 2]);
      end else if (i_paddr == `CMD_OFS) begin
        nxt_result = check_cmd(bank_st_ff, i_pwdata[`CMD_BANK_LSB +: 4] == busy_bank_ff,
            i_pwdata[`CMD_BLK_BIT], cmd_type'(i_pwdata[`CMD_CODE_LSB +: 3]));
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cfg_ff <= cfg_type'(`CFG_RESET);
      busy_bank_ff <= 4'h0;
      bank_st_ff <= BK_IDLE;
      rmode_ff <= RM_ARRAY;
      result_ff <= '0;
      prdata_ff <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end else begin
      cfg_ff <= nxt_cfg;
      busy_bank_ff <= nxt_busy_bank;
      bank_st_ff <= nxt_bank_st;
      rmode_ff <= nxt_rmode;
      result_ff <= nxt_result;
      prdata_ff <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // link edge and enable detection
  assign edge_hit = cfg_ff.active_clock_edge_bit ? (pins2_ff.link_clk && !prev_ff.link_clk)
      : (!pins2_ff.link_clk && prev_ff.link_clk);
  assign le_fall = prev_ff.latch_en_n && !pins2_ff.latch_en_n;
  assign ce_fall = prev_ff.chip_en_n && !pins2_ff.chip_en_n;
  assign activity = (addr2_ff != prev_addr_ff) || (pins2_ff.chip_en_n != prev_ff.chip_en_n)
      || (pins2_ff.latch_en_n != prev_ff.latch_en_n);
  assign async_mode = cfg_ff.read_select_bit;
  assign next_word = word_addr(start_ff, word_n_ff + ADDR_W'(1), cfg_ff);

  always_comb begin
    nxt_bst = bst_ff;
    nxt_lat_cnt = lat_cnt_ff;
    nxt_hold = hold_ff;
    nxt_word_n = word_n_ff;
    nxt_start = start_ff;
    nxt_arr_addr = arr_addr_ff;
    nxt_gap_cnt = gap_cnt_ff;
    nxt_crossed = crossed_ff;
    nxt_single = single_ff;
    nxt_armed = armed_ff;
    nxt_valid = valid_ff;
    nxt_page = page_ff;
    nxt_acc_cnt = acc_cnt_ff;
    nxt_idle_cnt = idle_cnt_ff;
    nxt_standby = 1'b0;
    if (async_mode) begin
      nxt_bst = BS_IDLE;
      if (!pins2_ff.chip_en_n && (ce_fall || addr2_ff != prev_addr_ff)) begin
        nxt_arr_addr = addr2_ff;
        nxt_page = addr2_ff[ADDR_W-1:2];
        nxt_valid = 1'b0;
        if (ce_fall || addr2_ff[ADDR_W-1:2] != page_ff) begin
          nxt_acc_cnt = RAND_CYC;
        end else begin
          nxt_acc_cnt = PAGE_CYC;
        end
      end else if (pins2_ff.chip_en_n) begin
        nxt_valid = 1'b0;
        nxt_acc_cnt = 8'h00;
      end else if (acc_cnt_ff != 8'h00) begin
        nxt_acc_cnt = acc_cnt_ff - 8'h01;
        nxt_valid = (acc_cnt_ff == 8'h01);
      end
      if (activity) begin
        nxt_idle_cnt = 8'h00;
      end else if (idle_cnt_ff < STBY_CYC) begin
        nxt_idle_cnt = idle_cnt_ff + 8'h01;
      end
      nxt_standby = !activity && (idle_cnt_ff >= STBY_CYC);
    end else begin
      nxt_idle_cnt = 8'h00;
      if (le_fall || ce_fall) begin
        nxt_armed = !pins2_ff.chip_en_n && !pins2_ff.latch_en_n;
      end
      if (pins2_ff.chip_en_n) begin
        nxt_bst = BS_IDLE;
        nxt_valid = 1'b0;
        nxt_armed = 1'b0;
      end else if (edge_hit && armed_ff) begin
        nxt_armed = 1'b0;
        nxt_bst = BS_LAT;
        nxt_start = addr2_ff;
        nxt_arr_addr = addr2_ff;
        nxt_word_n = '0;
        nxt_lat_cnt = cfg_ff.first_data_delay_field;
        nxt_hold = 1'b0;
        nxt_crossed = 1'b0;
        nxt_single = (rmode_ff != RM_ARRAY);
        nxt_valid = 1'b0;
      end else if (edge_hit) begin
        case (bst_ff)
          BS_LAT: begin
            nxt_lat_cnt = lat_cnt_ff - 3'h1;
            if (lat_cnt_ff <= 3'h1) begin
              nxt_bst = BS_DATA;
              nxt_valid = 1'b1;
            end
          end
          BS_DATA: begin
            if (cfg_ff.data_hold_bit && !hold_ff) begin
              nxt_hold = 1'b1;
            end else begin
              nxt_hold = 1'b0;
              nxt_word_n = word_n_ff + ADDR_W'(1);
              nxt_arr_addr = next_word;
              if (single_ff || (cfg_ff.burst_length_field == `LEN_4
                  && word_n_ff == ADDR_W'(`WORDS_4)) || (cfg_ff.burst_length_field == `LEN_8
                  && word_n_ff == ADDR_W'(`WORDS_8))) begin
                nxt_bst = BS_END;
                nxt_valid = 1'b0;
              end else if (next_word[`CROSS_BITS-1:0] == '0 && start_ff[1:0] != 2'h0
                  && !crossed_ff && (cfg_ff.burst_length_field == `LEN_CONT
                  || cfg_ff.wrap_select_bit)) begin
                nxt_bst = BS_GAP;
                nxt_gap_cnt = start_ff[1:0];
                nxt_crossed = 1'b1;
                nxt_valid = 1'b0;
              end
            end
          end
          BS_GAP: begin
            nxt_gap_cnt = gap_cnt_ff - 2'h1;
            if (gap_cnt_ff == 2'h1) begin
              nxt_bst = BS_DATA;
              nxt_valid = 1'b1;
            end
          end
          default: nxt_bst = bst_ff;
        endcase
      end
    end
    // wait released only on valid array burst data
    nxt_wait_asrt = !(nxt_bst == BS_DATA && nxt_valid && !async_mode
        && rmode_ff == RM_ARRAY);
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bst_ff <= BS_IDLE;
      lat_cnt_ff <= 3'h0;
      hold_ff <= 1'b0;
      word_n_ff <= '0;
      start_ff <= '0;
      arr_addr_ff <= '0;
      gap_cnt_ff <= 2'h0;
      crossed_ff <= 1'b0;
      single_ff <= 1'b0;
      armed_ff <= 1'b0;
      valid_ff <= 1'b0;
      wait_asrt_ff <= 1'b1;
      standby_ff <= 1'b0;
      page_ff <= '0;
      acc_cnt_ff <= 8'h00;
      idle_cnt_ff <= 8'h00;
      data_ff <= '0;
    end else begin
      bst_ff <= nxt_bst;
      lat_cnt_ff <= nxt_lat_cnt;
      hold_ff <= nxt_hold;
      word_n_ff <= nxt_word_n;
      start_ff <= nxt_start;
      arr_addr_ff <= nxt_arr_addr;
      gap_cnt_ff <= nxt_gap_cnt;
      crossed_ff <= nxt_crossed;
      single_ff <= nxt_single;
      armed_ff <= nxt_armed;
      valid_ff <= nxt_valid;
      wait_asrt_ff <= nxt_wait_asrt;
      standby_ff <= nxt_standby;
      page_ff <= nxt_page;
      acc_cnt_ff <= nxt_acc_cnt;
      idle_cnt_ff <= nxt_idle_cnt;
      data_ff <= i_array_data;
    end
  end

  // checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  a_async_wait_held: assert property (async_mode && $past(async_mode) |-> wait_asrt_ff)
    else $error("wait released in async mode");
  a_standby_entry: assert property (async_mode && !activity && idle_cnt_ff >= STBY_CYC
      |=> standby_ff)
    else $error("standby not entered");
  a_page_hit_fast: assert property (async_mode && !pins2_ff.chip_en_n && !ce_fall
      && addr2_ff != prev_addr_ff && addr2_ff[ADDR_W-1:2] == page_ff
      |=> acc_cnt_ff == PAGE_CYC)
    else $error("page hit not fast");
  a_page_miss_slow: assert property (async_mode && !pins2_ff.chip_en_n
      && addr2_ff[ADDR_W-1:2] != page_ff && addr2_ff != prev_addr_ff
      |=> acc_cnt_ff == RAND_CYC && !valid_ff)
    else $error("page miss not slow");
  a_latency_load: assert property (!async_mode && !pins2_ff.chip_en_n && edge_hit && armed_ff
      |=> bst_ff == BS_LAT && lat_cnt_ff == $past(cfg_ff.first_data_delay_field))
    else $error("latency not loaded");
  a_wait_release: assert property (!wait_asrt_ff |-> bst_ff == BS_DATA && valid_ff
      && rmode_ff == RM_ARRAY)
    else $error("wait released without data");
  a_wrap_confine: assert property (bst_ff == BS_DATA && !async_mode && !cfg_ff.wrap_select_bit
      && cfg_ff.burst_length_field == `LEN_4
      |-> arr_addr_ff[ADDR_W-1:2] == start_ff[ADDR_W-1:2])
    else $error("wrapped burst left group");
  a_gap_length: assert property ($rose(bst_ff == BS_GAP) |-> gap_cnt_ff == start_ff[1:0]
      && gap_cnt_ff != 2'h0)
    else $error("gap length wrong");
  a_single_word: assert property (bst_ff == BS_DATA && single_ff && edge_hit && !hold_ff
      && !cfg_ff.data_hold_bit |=> bst_ff == BS_END)
    else $error("single read ran on");
  a_busy_no_prog: assert property (i_psel && i_penable && i_pwrite && i_paddr == `CMD_OFS
      && bank_st_ff == BK_PROG && i_pwdata[`CMD_CODE_LSB +: 3] == CMD_PROGRAM
      |=> !result_ff.accepted)
    else $error("second program accepted");

  c_burst_end: cover property (bst_ff == BS_DATA ##1 bst_ff == BS_END);
  c_gap: cover property ($rose(bst_ff == BS_GAP));
  c_standby: cover property ($rose(standby_ff));
  c_undefined: cover property (result_ff.undefined_data);
endmodule : flash_read_core

// *** flash_read_regs.svh ***
// register offsets, reset values and timing counts of the flash read block
`ifndef FLASH_READ_REGS_SVH
`define FLASH_READ_REGS_SVH
`define CFG_OFS 12'h000
`define BANK_OFS 12'h004
`define CMD_OFS 12'h008
`define STAT_OFS 12'h00C
`define CFG_RESET 16'hBFCF
`define LEN_4 3'h1
`define LEN_8 3'h2
`define LEN_CONT 3'h7
`define WORDS_4 3'h3
`define WORDS_8 3'h7
`define BANK_ID_LSB 0
`define BANK_ST_LSB 4
`define BANK_RM_LSB 8
`define CMD_CODE_LSB 0
`define CMD_BANK_LSB 4
`define CMD_BLK_BIT 8
`define CLK_NS 4
`define STANDBY_NS 150
`define STANDBY_CYC ((`STANDBY_NS + `CLK_NS - 1) / `CLK_NS)
`define CROSS_BITS 6
`endif

// *** flash_read_pkg.sv ***
// types shared by the flash read block
package flash_read_pkg;
  typedef struct packed {
    logic read_select_bit;
    logic rsv14;
    logic [2:0] first_data_delay_field;
    logic wait_polarity_bit;
    logic data_hold_bit;
    logic wait_config;
    logic burst_order_bit;
    logic active_clock_edge_bit;
    logic [1:0] rsv5_4;
    logic wrap_select_bit;
    logic [2:0] burst_length_field;
  } cfg_type;
  typedef enum logic [2:0] {
    BK_IDLE = 3'h0, BK_PROG = 3'h1, BK_ERASE = 3'h2, BK_PSUSP = 3'h3, BK_ESUSP = 3'h4
  } bank_state_type;
  typedef enum logic [2:0] {
    CMD_RD_ARRAY = 3'h0, CMD_RD_STATUS = 3'h1, CMD_RD_CFI = 3'h2, CMD_RD_SIG = 3'h3,
    CMD_PROGRAM = 3'h4, CMD_ERASE = 3'h5, CMD_SUSPEND = 3'h6, CMD_RESUME = 3'h7
  } cmd_type;
  typedef enum logic [1:0] {
    RM_ARRAY = 2'h0, RM_STATUS = 2'h1, RM_CFI = 2'h2, RM_SIG = 2'h3
  } rmode_type;
  typedef enum logic [2:0] {
    BS_IDLE = 3'h0, BS_LAT = 3'h1, BS_DATA = 3'h2, BS_GAP = 3'h3, BS_END = 3'h4
  } burst_state_type;
  typedef struct packed {
    logic link_clk;
    logic chip_en_n;
    logic latch_en_n;
  } ctl_pins_type;
  typedef struct packed {
    logic accepted;
    logic undefined_data;
  } cmd_result_type;
endpackage : flash_read_pkg

// *** host_model.sv ***
// host controller model: flash enables, address and link clock
`timescale 1ns/100ps
module host_model
  import flash_read_pkg::*;
#(
  parameter int ADDR_W = 21
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // requests from the bench
  input wire logic i_go,
  input wire logic [ADDR_W-1:0] i_start,
  input wire logic [7:0] i_edges,
  // flash side
  output ctl_pins_type o_pins,
  output logic [ADDR_W-1:0] o_addr,
  output logic o_busy
);
  logic [ADDR_W-1:0] start_ff;
  logic [9:0] ph_ff;
  logic [8:0] left_ff;
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pins <= 3'h3;
      o_addr <= '0;
      start_ff <= '0;
      ph_ff <= '0;
      left_ff <= '0;
      o_busy <= 1'h0;
    end else if (i_go && i_edges == 8'h00) begin
      // async access: enables low, address steady, clock still
      o_pins <= 3'h0;
      o_addr <= i_start;
    end else if (i_go) begin
      // enables up first so each burst sees a fresh fall
      o_pins <= 3'h3;
      start_ff <= i_start;
      left_ff <= {i_edges, 1'h0};
      ph_ff <= '0;
      o_busy <= 1'h1;
    end else if (o_busy) begin
      ph_ff <= ph_ff + 10'h001;
      if (ph_ff == 10'h003) begin
        o_pins.chip_en_n <= 1'h0;
        o_pins.latch_en_n <= 1'h0;
        o_addr <= start_ff;
      end
      if (ph_ff == 10'h007) begin
        o_pins.latch_en_n <= 1'h1;
      end
      // scramble only once the first active link edge has taken the start
      if (ph_ff == 10'h013) begin
        o_addr <= ~start_ff;
      end
      if (ph_ff >= 10'h00B && ph_ff[1:0] == 2'h3) begin
        if (left_ff != 9'h000) begin
          o_pins.link_clk <= ~o_pins.link_clk;
          left_ff <= left_ff - 9'h001;
        end else begin
          o_pins.chip_en_n <= 1'h1;
          o_busy <= 1'h0;
        end
      end
    end
  end
endmodule : host_model

// *** testbench.sv ***
// self-checking bench for the flash read block
`timescale 1ns/100ps
`include "flash_read_regs.svh"
module testbench;
  import flash_read_pkg::*;
  typedef struct {logic [31:0] val; logic [31:0] mask; logic err;} apb_exp_type;
  typedef struct {logic [20:0] addr; int span;} word_exp_type;
  logic i_clock = 1'h0;
  logic i_rst_n = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, go = 1'h0, pol = 1'h1, single = 1'h0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, wait_pin, valid, standby, busy, prev_valid = 1'h0;
  ctl_pins_type pins;
  logic [20:0] addr, arr_addr, prev_addr, start = '0;
  logic [15:0] data, arr_data;
  logic [7:0] edges = '0;
  logic [31:0] lfsr = 32'h15E58C4C;
  logic [7:0] masks [5] = '{8'hFF, 8'h4F, 8'h4F, 8'h8F, 8'h9F};
  apb_exp_type apb_q[$];
  word_exp_type word_q[$];
  int fail_count = 0, checked = 0, cycles = 0, extra = 0, gap_cnt = 0, t1, t2, t3;
  always #2 i_clock = ~i_clock;
  function automatic logic [15:0] pat(input logic [20:0] a);
    return a[15:0] ^ 16'h5A3C;
  endfunction : pat
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : next_rand
  assign arr_data = pat(arr_addr);
  flash_read_core dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_pready(pready), .o_pslverr(pslverr), .o_prdata(prdata), .i_pins(pins),
    .i_addr(addr), .o_wait(wait_pin), .o_data(data), .o_data_valid(valid),
    .o_standby(standby), .o_array_addr(arr_addr), .i_array_data(arr_data));
  host_model host (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_go(go), .i_start(start),
    .i_edges(edges), .o_pins(pins), .o_addr(addr), .o_busy(busy));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic results;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clock);
    penable <= 1'h1;
    do @(posedge i_clock); while (pready !== 1'h1);
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge i_clock);
  endtask : apb
  task automatic apb_rd(input logic [11:0] a, input logic [31:0] v, input logic [31:0] m,
                        input logic e);
    apb_q.push_back('{v, m, e});
    apb(1'h0, a, 32'h0);
  endtask : apb_rd
  task automatic async_go(input logic [20:0] a, output int t);
    start <= a;
    edges <= 8'h00;
    go <= 1'h1;
    @(posedge i_clock);
    go <= 1'h0;
    repeat (6) @(posedge i_clock);
    t = 6;
    while (valid !== 1'h1) begin
      @(posedge i_clock);
      t++;
    end
  endtask : async_go
  task automatic burst(input logic [2:0] lat, input logic p, input logic hold,
    input logic ord, input logic edg, input logic nowrap, input logic [2:0] len,
    input logic [20:0] s, input int nw);
    cfg_type c;
    int n, h, gp, k, off, base, sp;
    logic [20:0] a;
    c = '0;
    c.first_data_delay_field = lat;
    c.wait_polarity_bit = p;
    c.data_hold_bit = hold;
    c.wait_config = 1'h1;
    c.burst_order_bit = ord;
    c.active_clock_edge_bit = edg;
    c.wrap_select_bit = nowrap;
    c.burst_length_field = len;
    apb(1'h1, `CFG_OFS, {16'h0000, c});
    pol = p;
    n = (len == `LEN_4) ? 4 : 8;
    h = hold ? 2 : 1;
    gp = (nowrap || len == `LEN_CONT) ? int'(s[1:0]) : 0;
    off = int'(s) & (n - 1);
    base = int'(s) & ~(n - 1);
    for (k = 0; k < nw; k++) begin
      if (!ord) a = 21'(base | (off ^ k));
      else if (!nowrap && len != `LEN_CONT) a = 21'(base | ((off + k) & (n - 1)));
      else a = s + 21'(k);
      sp = (k == 0) ? 0 : 8 * (h + ((a[5:0] == 6'h00) ? gp : 0));
      word_q.push_back('{a, sp});
    end
    extra = 0;
    start <= s;
    edges <= 8'(lat + nw * h + gp + 3);
    go <= 1'h1;
    @(posedge i_clock);
    go <= 1'h0;
    @(posedge i_clock);
    while (busy === 1'h1 || valid === 1'h1) @(posedge i_clock);
    @(posedge i_clock);
    check("words left", word_q.size(), 0);
    if (len != `LEN_CONT) check("extra words", extra, 0);
    check("wait idle", {31'h0, wait_pin}, {31'h0, p});
  endtask : burst
  task automatic cmd_case(input int st, input int cm, input int tg);
    logic [3:0] b, tb;
    logic [7:0] mk;
    b = lfsr[3:0];
    lfsr = next_rand(lfsr);
    tb = (tg == 0) ? b ^ {lfsr[2:0], 1'h1} : b;
    mk = (tg == 2 && st >= 3) ? 8'h8E : masks[st];
    apb(1'h1, `BANK_OFS, 32'(st << 4) | {28'h0, b});
    apb(1'h1, `CMD_OFS, {23'h0, 1'(tg == 2), tb, 1'h0, 3'(cm)});
    apb_rd(`STAT_OFS, {30'h0, mk[cm], 1'(tg != 0 && (st == 1 || st == 2) && cm == 0)},
           32'h3, 1'h0);
  endtask : cmd_case
  always @(posedge i_clock) begin : watch
    apb_exp_type ae;
    word_exp_type we;
    if (psel && penable && pready && !pwrite && apb_q.size() > 0) begin
      ae = apb_q.pop_front();
      check("prdata", prdata & ae.mask, ae.val);
      check("pslverr", {31'h0, pslverr}, {31'h0, ae.err});
    end
    gap_cnt++;
    if (valid && (!prev_valid || arr_addr != prev_addr)) begin
      if (word_q.size() == 0) extra++;
      else begin
        we = word_q.pop_front();
        check("word address", {11'h0, arr_addr}, {11'h0, we.addr});
        if (we.span != 0) check("word spacing", gap_cnt, we.span);
        check("wait in data", {31'h0, wait_pin}, {31'h0, single ? pol : ~pol});
      end
      gap_cnt = 0;
    end
    prev_valid = valid;
    prev_addr = arr_addr;
  end
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 30000) begin
      fail_count++;
      results();
    end
  end
  initial begin
    repeat (12) @(posedge i_clock);
    i_rst_n <= 1'h1;
    @(posedge i_clock);
    apb_rd(`CFG_OFS, 32'h0000BFCF, 32'hFFFFFFFF, 1'h0);
    apb_rd(12'h010, 32'h0, 32'hFFFFFFFF, 1'h1);
    async_go(21'h01200, t1);
    check("async wait", {31'h0, wait_pin}, 32'h1);
    async_go(21'h01202, t2);
    repeat (2) @(posedge i_clock);
    check("page data", {16'h0, data}, {16'h0, pat(21'h01202)});
    async_go(21'h01206, t3);
    check("page gain", t1 - t2, 11);
    check("page miss", t3, t1);
    check("awake", {31'h0, standby}, 32'h0);
    repeat (40) @(posedge i_clock);
    check("standby", {31'h0, standby}, 32'h1);
    apb_rd(`STAT_OFS, 32'h4, 32'h4, 1'h0);
    burst(3'h2, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0, `LEN_4, 21'h00102, 4);
    burst(3'h5, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0, `LEN_8, 21'h00205, 8);
    burst(3'h2, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0, `LEN_4, 21'h00503, 4);
    burst(3'h3, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1, `LEN_8, 21'h00308, 8);
    burst(3'h3, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0, `LEN_8, 21'h00308, 8);
    burst(3'h4, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1, `LEN_4, 21'h0033D, 4);
    burst(3'h2, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1, `LEN_CONT, 21'h0043E, 6);
    apb(1'h1, `BANK_OFS, 32'h00000100);
    single = 1'h1;
    burst(3'h3, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0, `LEN_4, 21'h00601, 1);
    single = 1'h0;
    for (int st = 0; st < 5; st++)
      for (int cm = 0; cm < 8; cm++)
        for (int tg = 0; tg < 3; tg++)
          cmd_case(st, cm, tg);
    check("reads pending", apb_q.size(), 0);
    results();
  end
endmodule : testbench
